/* twd_pkg.sv */
package twd_pkg;
  localparam int WORD_W        = 20;
  localparam int CTRL_BIT      = 19;
  localparam int PAR_BIT       = 0;
  localparam int DEST_LSB      = 16;
  localparam int MODE_W        = 5;
  localparam int WC_W          = 7;
  localparam int WC_LOAD_BIT   = 14;
  localparam int WC_LSB        = 7;
  localparam int INHIBIT_BIT   = 15;
  localparam int COORD_W       = 9;
  localparam int COORD_SEL_BIT = 10;
  localparam int ECHO_W        = 7;
  localparam int MAR_W         = 11;
  localparam int LDA_W         = 10;
  localparam int SLIDE_W       = 8;
  localparam int SHUTTER_BIT   = 9;
  localparam int LAMP_BIT      = 10;
  localparam int PAYLOAD_W     = 15;
  localparam int MEM_DATA_W    = 16;
  localparam int MEM_DEPTH     = 1024;
  localparam int ERASE_BIT     = 1;
  localparam int OPMODE_LSB    = 4;
  localparam logic [1:0] OPMODE_LINE = 2'h1;
  localparam logic [1:0] OPMODE_MEM  = 2'h2;
  localparam logic [2:0] DEST_NOP   = 3'h0;
  localparam logic [2:0] DEST_MODE  = 3'h1;
  localparam logic [2:0] DEST_COORD = 3'h2;
  localparam logic [2:0] DEST_ECHO  = 3'h3;
  localparam logic [2:0] DEST_ADDR  = 3'h4;
  localparam logic [2:0] DEST_SLIDE = 3'h5;
  localparam logic [2:0] DEST_AUDIO = 3'h6;
  localparam logic [2:0] DEST_EXT   = 3'h7;
  localparam logic [MODE_W-1:0] MODE_RST  = 5'h00;
  localparam logic [WC_W-1:0]   WC_RST    = 7'h00;
  localparam logic [MAR_W-1:0]  MAR_RST   = 11'h000;
  localparam logic [COORD_W-1:0] POS_RST  = 9'h000;
  typedef enum logic [1:0] {ST_IDLE, ST_DECODE} twd_state_t;
endpackage

/* twd_decoder.sv */
`timescale 1ns/1ns
// How it works
// - Shift serial bits into 20-bit register; process word when complete.
// - Bit 00 is odd parity over the word; host sets it, we check.
// - Bit 19 one means data word, zero means control word.
// - Control word: bits 16-18 destination, bits 01-15 payload.
// - Destination 000 is accepted but changes nothing.
// - Destination 001 loads mode from bits 01-05; mode holds until reload.
// - In abort, load-mode updates word counter but not mode.
// - Load-mode bit 15 blocks external inputs until cleared by another.
// - Destination 010 loads bits 01-09 into X or Y by bit 10.
// - Destination 011 sends bits 01-07 back to host.
// - Destination 100 loads memory address from bits 01-10.
// - Destination 101 sends bits 01-08 as slide number.
// - Slide bit 09 closes shutter until cleared; bit 10 drives lamp.
// - Destination 110 passes sector and track to audio unit.
// - Destination 111 forwards bits 01-15 to external channel.
// - Word counter increments for every accepted non-NOP word, unless load-mode bit 14 loads it from bits 07-13.
// - Parity failure sends word count to host and enters abort.
// - Abort rejects all but load-mode, which leaves abort.
// - Mode bit 01 triggers full erase; bits 04-05 select operating mode.
// - Line mode draws from position to data coordinates, keeps endpoint.
// - Memory mode stores 16-bit data at address, then increments address.
module twd_decoder #(
  parameter int WORD_BITS = twd_pkg::WORD_W
) (
  input  wire logic                               mclk,
  input  wire logic                               rst_n,
  input  wire logic                               ser_bit,
  input  wire logic                               ser_bit_valid,
  output logic [twd_pkg::MODE_W-1:0]              mode_word,
  output logic [twd_pkg::COORD_W-1:0]             horizontal_position,
  output logic [twd_pkg::COORD_W-1:0]             vertical_position,
  output logic [twd_pkg::MAR_W-1:0]               char_memory_address,
  output logic [twd_pkg::WC_W-1:0]                received_word_count,
  output logic                                    abort_state,
  output logic                                    ext_inhibit,
  output logic                                    echo_valid,
  output logic [twd_pkg::ECHO_W-1:0]              echo_value,
  output logic                                    wc_report_valid,
  output logic                                    screen_erase,
  output logic                                    line_draw,
  output logic [twd_pkg::COORD_W-1:0]             line_from_x,
  output logic [twd_pkg::COORD_W-1:0]             line_from_y,
  output logic [twd_pkg::SLIDE_W-1:0]             slide_number,
  output logic                                    slide_strobe,
  output logic                                    shutter_closed,
  output logic                                    lamp_on,
  output logic [twd_pkg::PAYLOAD_W-1:0]           audio_word,
  output logic                                    audio_strobe,
  output logic [twd_pkg::PAYLOAD_W-1:0]           ext_word,
  output logic                                    ext_strobe,
  output logic                                    mem_write,
  output logic [twd_pkg::MEM_DATA_W-1:0]          mem_wdata,
  output logic [twd_pkg::MAR_W-1:0]               mem_waddr
);
  import twd_pkg::*;

  logic [WORD_BITS-1:0]      serial_input_shift_r;
  logic [$clog2(WORD_BITS+1)-1:0] bit_cnt_r;
  logic                      word_ready_r;
  logic [WORD_BITS-1:0]      word_r;
  logic [MEM_DATA_W-1:0]     char_mem [MEM_DEPTH];
  twd_state_t                state_r;

  function automatic logic odd_ok(input logic [WORD_BITS-1:0] w);
    odd_ok = ^w;
  endfunction

  logic [2:0]  dest;
  logic        is_data;
  logic        par_ok;
  logic        accept;
  assign dest    = word_r[DEST_LSB +: 3];
  assign is_data = word_r[CTRL_BIT];
  assign par_ok  = odd_ok(word_r);
  assign accept  = par_ok && (!abort_state || (!is_data && dest == DEST_MODE));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial_input_shift_r <= '0;
      bit_cnt_r            <= '0;
      word_ready_r         <= 1'b0;
      word_r               <= '0;
    end else begin
      word_ready_r <= 1'b0;
      if (ser_bit_valid) begin
        serial_input_shift_r <= {serial_input_shift_r[WORD_BITS-2:0], ser_bit};
        if (bit_cnt_r == ($clog2(WORD_BITS+1))'(WORD_BITS - 1)) begin
          bit_cnt_r    <= '0;
          word_ready_r <= 1'b1;
          word_r       <= {serial_input_shift_r[WORD_BITS-2:0], ser_bit};
        end else begin
          bit_cnt_r <= bit_cnt_r + 1'b1;
        end
      end
    end
  end

  // Two-step control: capture, then decode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE:   state_r <= word_ready_r ? ST_DECODE : ST_IDLE;
        ST_DECODE: state_r <= ST_IDLE;
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  logic go;
  assign go = (state_r == ST_DECODE);

  // Abort state and word counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      abort_state         <= 1'b0;
      received_word_count <= WC_RST;
      wc_report_valid     <= 1'b0;
    end else begin
      wc_report_valid <= 1'b0;
      if (go) begin
        if (!par_ok) begin
          abort_state     <= 1'b1;
          wc_report_valid <= 1'b1;
        end else if (accept) begin
          if (!is_data && dest == DEST_MODE)
            abort_state <= 1'b0;
          if (!is_data && dest == DEST_MODE && word_r[WC_LOAD_BIT])
            received_word_count <= word_r[WC_LSB +: WC_W];
          else if (is_data || dest != DEST_NOP)
            received_word_count <= received_word_count + 1'b1;
        end
      end
    end
  end

  // Mode and inhibit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_word    <= MODE_RST;
      ext_inhibit  <= 1'b0;
      screen_erase <= 1'b0;
    end else begin
      screen_erase <= 1'b0;
      if (go && accept && !is_data && dest == DEST_MODE) begin
        ext_inhibit <= word_r[INHIBIT_BIT];
        if (!abort_state) begin
          mode_word    <= word_r[1 +: MODE_W];
          screen_erase <= word_r[ERASE_BIT];
        end
      end
    end
  end

  // Position, address and memory
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      horizontal_position <= POS_RST;
      vertical_position   <= POS_RST;
      char_memory_address <= MAR_RST;
      line_draw           <= 1'b0;
      line_from_x         <= POS_RST;
      line_from_y         <= POS_RST;
      mem_write           <= 1'b0;
      mem_wdata           <= '0;
      mem_waddr           <= MAR_RST;
    end else begin
      line_draw <= 1'b0;
      mem_write <= 1'b0;
      if (go && accept) begin
        if (is_data) begin
          if (mode_word[OPMODE_LSB-1 +: 2] == OPMODE_LINE) begin
            line_draw           <= 1'b1;
            line_from_x         <= horizontal_position;
            line_from_y         <= vertical_position;
            horizontal_position <= word_r[1 +: COORD_W];
            vertical_position   <= word_r[1+COORD_W +: COORD_W];
          end else if (mode_word[OPMODE_LSB-1 +: 2] == OPMODE_MEM) begin
            mem_write           <= 1'b1;
            mem_wdata           <= word_r[1 +: MEM_DATA_W];
            mem_waddr           <= char_memory_address;
            char_memory_address <= char_memory_address + 1'b1;
          end
        end else begin
          case (dest)
            DEST_COORD: begin
              if (word_r[COORD_SEL_BIT])
                vertical_position <= word_r[1 +: COORD_W];
              else
                horizontal_position <= word_r[1 +: COORD_W];
            end
            DEST_ADDR: char_memory_address <= {1'b0, word_r[1 +: LDA_W]};
            default: ;
          endcase
        end
      end
    end
  end

  // Only written, never read here; kept for the character generator
  always_ff @(posedge mclk) begin
    if (mem_write)
      char_mem[mem_waddr[$clog2(MEM_DEPTH)-1:0]] <= mem_wdata;
  end

  // Echo, slide, audio, external
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      echo_valid     <= 1'b0;
      echo_value     <= '0;
      slide_number   <= '0;
      slide_strobe   <= 1'b0;
      shutter_closed <= 1'b0;
      lamp_on        <= 1'b0;
      audio_word     <= '0;
      audio_strobe   <= 1'b0;
      ext_word       <= '0;
      ext_strobe     <= 1'b0;
    end else begin
      echo_valid   <= 1'b0;
      slide_strobe <= 1'b0;
      audio_strobe <= 1'b0;
      ext_strobe   <= 1'b0;
      if (go && !par_ok) begin
        // Count goes out as echo data
        echo_value <= received_word_count;
      end else if (go && accept && !is_data) begin
        case (dest)
          DEST_ECHO: begin
            echo_value <= word_r[1 +: ECHO_W];
            echo_valid <= 1'b1;
          end
          DEST_SLIDE: begin
            slide_number   <= word_r[1 +: SLIDE_W];
            slide_strobe   <= 1'b1;
            shutter_closed <= word_r[SHUTTER_BIT];
            lamp_on        <= word_r[LAMP_BIT];
          end
          DEST_AUDIO: begin
            // Host pairs words; passed as is
            audio_word   <= word_r[1 +: PAYLOAD_W];
            audio_strobe <= 1'b1;
          end
          DEST_EXT: begin
            ext_word   <= word_r[1 +: PAYLOAD_W];
            ext_strobe <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // twd_decoder

/* twd_decoder_chk.sv */
`timescale 1ns/1ns
module twd_decoder_chk (
  input wire logic                        mclk,
  input wire logic                        rst_n,
  input wire logic [twd_pkg::MODE_W-1:0]  mode_word,
  input wire logic [twd_pkg::MAR_W-1:0]   char_memory_address,
  input wire logic [twd_pkg::WC_W-1:0]    received_word_count,
  input wire logic                        abort_state,
  input wire logic                        echo_valid,
  input wire logic [twd_pkg::ECHO_W-1:0]  echo_value,
  input wire logic                        wc_report_valid,
  input wire logic                        screen_erase,
  input wire logic                        line_draw,
  input wire logic                        slide_strobe,
  input wire logic                        audio_strobe,
  input wire logic                        ext_strobe,
  input wire logic                        mem_write,
  input wire logic [twd_pkg::MAR_W-1:0]   mem_waddr
);
  import twd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_one_target: assert property (
    $onehot0({echo_valid, slide_strobe, audio_strobe, ext_strobe, mem_write, line_draw}))
    else $error("Two targets strobed together");
  chk_ext_pulse: assert property (ext_strobe |=> !ext_strobe)
    else $error("External strobe longer than one cycle");
  chk_report_abort: assert property (wc_report_valid |-> ##[0:2] abort_state)
    else $error("Parity report without abort");
  chk_report_value: assert property (
    wc_report_valid |-> echo_value == received_word_count)
    else $error("Reported value is not the word count");
  chk_report_nocount: assert property (
    wc_report_valid |-> $stable(received_word_count))
    else $error("Bad word changed the count");
  chk_abort_refuse: assert property (
    abort_state && $past(abort_state) |-> !(echo_valid | slide_strobe | audio_strobe
      | ext_strobe | mem_write | line_draw | screen_erase))
    else $error("Word dispatched while aborted");
  chk_mode_frozen: assert property ($changed(mode_word) |-> !$past(abort_state))
    else $error("Mode changed while aborted");
  chk_erase_mode: assert property (screen_erase |-> ##[0:1] mode_word[0])
    else $error("Erase without erase bit");
  chk_mem_step: assert property (
    mem_write |=> char_memory_address == $past(mem_waddr) + 11'h001)
    else $error("Address did not step after store");
  cover property (wc_report_valid);
  cover property (line_draw);
  cover property (mem_write);
  cover property (screen_erase);
endmodule // twd_decoder_chk

bind twd_decoder twd_decoder_chk chk (.*);

/* twd_host.sv */
`timescale 1ns/1ns
module twd_host (
  input wire logic mclk,
  output logic     ser_bit,
  output logic     ser_bit_valid
);
  initial begin
    ser_bit = 1'b0;
    ser_bit_valid = 1'b0;
  end
  task automatic send(input logic [18:0] v, input bit bad);
    logic [19:0] w;
    w = {v, ~(^v) ^ bad};
    for (int i = 19; i >= 0; i--) begin
      @(posedge mclk);
      ser_bit <= w[i];
      ser_bit_valid <= 1'b1;
    end
    @(posedge mclk);
    ser_bit_valid <= 1'b0;
    // Idle line toggles so a stale bit is never mistaken for data
    ser_bit <= ~w[0];
  endtask
endmodule // twd_host

/* twd_decoder_bench.sv */
`timescale 1ns/1ns
module twd_decoder_bench;
  import twd_pkg::*;
  logic mclk, rst_n, ser_bit, ser_bit_valid, abort_state, ext_inhibit, echo_valid;
  logic wc_report_valid, screen_erase, line_draw, slide_strobe, shutter_closed, lamp_on;
  logic audio_strobe, ext_strobe, mem_write;
  logic [MODE_W-1:0] mode_word, em;
  logic [COORD_W-1:0] horizontal_position, vertical_position, line_from_x, line_from_y, ex, ey;
  logic [MAR_W-1:0] char_memory_address, mem_waddr, ea;
  logic [WC_W-1:0] received_word_count, echo_value, ec;
  logic [SLIDE_W-1:0] slide_number;
  logic [PAYLOAD_W-1:0] audio_word, ext_word;
  logic [MEM_DATA_W-1:0] mem_wdata;
  logic [34:0] q[$];
  logic [34:0] obs;
  logic [7:0] st;
  logic [31:0] r;
  logic eab, ein;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  twd_decoder dut (.*);
  twd_host host (.mclk(mclk), .ser_bit(ser_bit), .ser_bit_valid(ser_bit_valid));
  assign st = {echo_valid & ~wc_report_valid, wc_report_valid, screen_erase, line_draw,
    slide_strobe, audio_strobe, ext_strobe, mem_write};
  assign obs = {st, mem_write ? mem_waddr : line_draw ? {2'h0, line_from_y} : 11'h000,
    mem_write ? mem_wdata : line_draw ? {7'h00, line_from_x} : ext_strobe ? {1'b0, ext_word}
    : audio_strobe ? {1'b0, audio_word} : slide_strobe ? {6'h00, lamp_on, shutter_closed,
    slide_number} : |st[7:6] ? {9'h000, echo_value} : 16'h0000};
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(negedge mclk) begin
    if (rst_n && |st) begin
      check(obs, (q.size() != 0) ? q.pop_front() : '1);
    end
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  // Reference decode, then send and compare the registers
  task automatic word(input logic [18:0] v, input bit bad);
    logic [14:0] p;
    logic [2:0] d;
    p = v[14:0];
    d = v[17:15];
    if (bad) begin
      q.push_back({8'h40, 20'h00000, ec});
      eab = 1'b1;
    end else if (eab && (v[18] || d != DEST_MODE)) begin
    end else if (v[18]) begin
      ec = ec + 7'h01;
      if (em[4:3] == OPMODE_LINE) begin
        q.push_back({8'h10, 2'h0, ey, 7'h00, ex});
        ex = v[8:0];
        ey = v[17:9];
      end else if (em[4:3] == OPMODE_MEM) begin
        q.push_back({8'h01, ea, v[15:0]});
        ea = ea + 11'h001;
      end
    end else begin
      if (d != DEST_NOP) ec = ec + 7'h01;
      case (d)
        DEST_MODE: begin
          if (!eab && p[0]) q.push_back({8'h20, 27'h0000000});
          if (!eab) em = p[4:0];
          if (p[13]) ec = p[12:6];
          ein = p[14];
          eab = 1'b0;
        end
        DEST_COORD: if (p[9]) ey = p[8:0]; else ex = p[8:0];
        DEST_ECHO: q.push_back({8'h80, 20'h00000, p[6:0]});
        DEST_ADDR: ea = {1'b0, p[9:0]};
        DEST_SLIDE: q.push_back({8'h08, 17'h00000, p[9:0]});
        DEST_AUDIO: q.push_back({8'h04, 12'h000, p});
        DEST_EXT: q.push_back({8'h02, 12'h000, p});
        default: ;
      endcase
    end
    host.send(v, bad);
    repeat (5) @(posedge mclk);
    #1;
    check({mode_word, horizontal_position, vertical_position, char_memory_address,
      received_word_count, abort_state, ext_inhibit}, {em, ex, ey, ea, ec, eab, ein});
  endtask
  initial begin
    rst_n = 1'b0;
    {em, ex, ey, ea, ec, eab, ein} = '0;
    void'($urandom(32'h40E8));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    r = $urandom();
    word({1'b0, DEST_NOP, r[14:0]}, 1'b0);
    // Erase, line mode, count preload, inhibit
    word({1'b0, DEST_MODE, 15'h7F89}, 1'b0);
    for (int i = 0; i < 12; i++) begin
      r = $urandom();
      word({1'b0, 3'(2 + i % 6), r[14:0]}, 1'b0);
      // second audio word has bit 15 clear
      if (i % 6 == 4) word({1'b0, DEST_AUDIO, 1'b0, r[29:16]}, 1'b0);
    end
    repeat (3) begin
      r = $urandom();
      word({1'b1, r[17:0]}, 1'b0);
    end
    word({1'b0, DEST_MODE, 15'h0010}, 1'b0);
    word({1'b0, DEST_ADDR, 15'h03FE}, 1'b0);
    repeat (3) begin
      r = $urandom();
      word({1'b1, r[17:0]}, 1'b0);
    end
    word({1'b0, DEST_EXT, r[14:0]}, 1'b1);
    word({1'b0, DEST_ECHO, r[30:16]}, 1'b0);
    word({1'b1, r[17:0]}, 1'b0);
    word({1'b0, DEST_MODE, 15'h0001}, 1'b0);
    word({1'b0, DEST_ECHO, r[29:15]}, 1'b0);
    check(48'(q.size()), 48'h0);
    results();
  end
endmodule // twd_decoder_bench
